// file: core/dcser_pkg.sv
`default_nettype none
package dcser_pkg;
	// frame layout
	localparam int DCSER_FRAME_BITS = 16;
	localparam int DCSER_CMD_HI = 13;
	localparam int DCSER_CMD_LO = 11;
	localparam int DCSER_DATA_W = 10;
	localparam int DCSER_CFG_APPLY_EDGE = 14;
	// commands
	localparam logic [2:0] DCSER_CMD_NOP = 3'h0;
	localparam logic [2:0] DCSER_CMD_WRCFG = 3'h1;
	localparam logic [2:0] DCSER_CMD_RDERR = 3'h4;
	localparam logic [2:0] DCSER_CMD_RDCFG = 3'h5;
	// error field positions
	localparam int DCSER_ERR_INTERMIT = 9;
	localparam int DCSER_ERR_SHORT = 8;
	localparam int DCSER_ERR_OPEN = 7;
	localparam int DCSER_ERR_OVERTEMP = 6;
	localparam int DCSER_ERR_BROWNOUT = 5;
	// configuration field positions
	localparam int DCSER_CFG_MODE_LO = 7;
	localparam int DCSER_CFG_BOTH_LO = 4;
	localparam int DCSER_CFG_THERM = 3;
	localparam logic [9:0] DCSER_CFG_RESET = 10'h000;
	localparam logic [9:0] DCSER_CFG_MASK = 10'h3F8;
	localparam logic [9:0] DCSER_ERR_RESET = 10'h000;
	// clock timing
	localparam int DCSER_MCLK_HZ = 10000000;
endpackage : dcser_pkg
`default_nettype wire

// file: core/dcser_sync.sv
`default_nettype none
module dcser_sync
	import dcser_pkg::*;
#(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] IDLE = '1
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} dcser_sync_s;
	dcser_sync_s state_reg;
	dcser_sync_s state_next;

	// meta stage is read only by the stable stage
	always_comb begin
		state_next = state_reg;
		if (clk_en) begin
			state_next.meta = async_in;
			state_next.stable = state_reg.meta;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			// idle level of the pins, so no false event after reset
			state_reg <= '{meta: IDLE, stable: IDLE};
		end else begin
			state_reg <= state_next;
		end
	end

	assign sync_out = state_reg.stable;
endmodule : dcser_sync
`default_nettype wire

// file: core/dcser_errlog.sv
`default_nettype none
module dcser_errlog
	import dcser_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic [3:0] fault_live,
	input wire logic read_pulse,
	output logic [9:0] err_field,
	output logic err_irq
);
	// fault_live: 3 short, 2 open, 1 overtemp, 0 brownout (mclk domain)
	typedef struct packed {
		logic [3:0] latched;
		logic [3:0] reported;
		logic intermit;
		logic irq;
		logic armed;
	} dcser_errlog_s;
	dcser_errlog_s state_reg;
	dcser_errlog_s state_next;

	logic [3:0] new_faults;

	always_comb begin
		state_next = state_reg;
		new_faults = fault_live & ~state_reg.reported;
		if (clk_en) begin
			if (read_pulse) begin
				if (state_reg.armed) begin
					state_next.latched = fault_live;
					state_next.intermit = 1'b0;
					state_next.armed = 1'b0;
					// cleared faults may report again when they return
					state_next.reported = fault_live;
				end else begin
					state_next.armed = 1'b1;
					state_next.reported = state_reg.latched | fault_live;
				end
				state_next.irq = 1'b0;
			end
			// short or open vanished; judged after a clear
			if ((state_next.latched[3:2] & ~fault_live[3:2]) != 2'b00) begin
				state_next.intermit = 1'b1;
			end
			state_next.latched = state_next.latched | fault_live;
			// only new faults; set beats clear
			if (new_faults != 4'h0) begin
				state_next.irq = 1'b1;
				state_next.reported = state_next.reported | new_faults;
				state_next.armed = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// error field layout; one bit each
	always_comb begin
		err_field = DCSER_ERR_RESET;
		err_field[DCSER_ERR_INTERMIT] = state_reg.intermit;
		err_field[DCSER_ERR_SHORT] = state_reg.latched[3];
		err_field[DCSER_ERR_OPEN] = state_reg.latched[2];
		err_field[DCSER_ERR_OVERTEMP] = state_reg.latched[1];
		err_field[DCSER_ERR_BROWNOUT] = state_reg.latched[0];
	end

	assign err_irq = state_reg.irq;
endmodule : dcser_errlog
`default_nettype wire

// file: core/dcser_slave.sv
`default_nettype none
module dcser_slave
	import dcser_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic chip_select_a_n,
	input wire logic chip_select_b_n,
	input wire logic serial_clk,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_en,
	output logic frame_done_n,
	input wire logic fault_short,
	input wire logic fault_open,
	input wire logic fault_overtemp,
	input wire logic fault_brownout,
	output logic error_irq_out,
	output logic error_irq_en,
	output logic [2:0] cfg_mode,
	output logic [2:0] cfg_brownout_thr,
	output logic cfg_thermal_en
);
	// ***********************************
	// types and state
	// ***********************************
	typedef enum logic [1:0] {
		DCSER_IDLE,
		DCSER_SHIFT,
		DCSER_DONE
	} dcser_phase_e;

	typedef struct packed {
		dcser_phase_e phase;
		logic [4:0] count;
		logic [15:0] shift_in;
		logic [9:0] shift_out;
		logic [2:0] cmd;
		logic [9:0] cfg;
		logic sclk_prev;
		logic out_bit;
		logic drive;
		logic done;
		logic rd_err;
		logic [3:0] faults;
	} dcser_slave_s;

	dcser_slave_s state_reg;
	dcser_slave_s state_next;

	// ***********************************
	// input synchronisers
	// ***********************************
	logic [3:0] pins_sync;
	logic [3:0] faults_sync;
	logic sel_n;
	logic sclk_s;
	logic din_s;
	logic sclk_fall;
	logic [9:0] err_field;
	logic err_irq;

	dcser_sync #(
		.WIDTH(4)
	) u_pin_sync (
		.mclk(mclk),
		.reset(reset),
		.clk_en(clk_en),
		.async_in({chip_select_a_n, chip_select_b_n, serial_clk, serial_in}),
		.sync_out(pins_sync)
	);

	// faults come from the analog side, treated as asynchronous; idle low
	dcser_sync #(
		.WIDTH(4),
		.IDLE(4'h0)
	) u_fault_sync (
		.mclk(mclk),
		.reset(reset),
		.clk_en(clk_en),
		.async_in({fault_short, fault_open, fault_overtemp, fault_brownout}),
		.sync_out(faults_sync)
	);

	// selects are or-ed: either high deselects
	assign sel_n = pins_sync[3] | pins_sync[2];
	assign sclk_s = pins_sync[1];
	assign din_s = pins_sync[0];
	assign sclk_fall = state_reg.sclk_prev & ~sclk_s;

	// ***********************************
	// error log
	// ***********************************
	dcser_errlog u_errlog (
		.mclk(mclk),
		.reset(reset),
		.clk_en(clk_en),
		.fault_live(faults_sync),
		.read_pulse(state_reg.rd_err),
		.err_field(err_field),
		.err_irq(err_irq)
	);

	// ***********************************
	// frame engine
	// ***********************************
	logic [15:0] word_now;
	logic [4:0] count_inc;

	always_comb begin
		state_next = state_reg;
		state_next.sclk_prev = sclk_s;
		state_next.rd_err = 1'b0;
		state_next.faults = faults_sync;
		word_now = {state_reg.shift_in[14:0], din_s};
		count_inc = state_reg.count + 5'h01;
		if (clk_en) begin
			if (sel_n) begin
				state_next.phase = DCSER_IDLE;
				state_next.count = 5'h00;
				state_next.drive = 1'b0;
				state_next.done = 1'b0;
				state_next.cmd = DCSER_CMD_NOP;
				state_next.shift_out = 10'h000;
			end else begin
				case (state_reg.phase)
					DCSER_IDLE: begin
						state_next.phase = DCSER_SHIFT;
						state_next.drive = 1'b1;
						state_next.out_bit = 1'b0;
						state_next.count = 5'h00;
					end
					DCSER_SHIFT: begin
						if (sclk_fall) begin
							state_next.shift_in = word_now;
							state_next.count = count_inc;
							if (count_inc == 5'(DCSER_FRAME_BITS - DCSER_CMD_LO)) begin
								state_next.cmd = word_now[DCSER_CMD_HI - DCSER_CMD_LO:0];
								case (word_now[2:0])
									DCSER_CMD_RDERR: begin
										state_next.shift_out = err_field;
									end
									DCSER_CMD_RDCFG: begin
										state_next.shift_out = state_reg.cfg;
									end
									default: begin
										state_next.shift_out = 10'h000;
									end
								endcase
							end
							if (count_inc == 5'(DCSER_CFG_APPLY_EDGE) && state_reg.cmd == DCSER_CMD_WRCFG) begin
								state_next.cfg = {word_now[7:0], 2'b00} & DCSER_CFG_MASK;
							end
							if (count_inc == 5'(DCSER_FRAME_BITS)) begin
								state_next.phase = DCSER_DONE;
								state_next.done = 1'b1;
								state_next.drive = 1'b0;
								state_next.rd_err = (state_reg.cmd == DCSER_CMD_RDERR);
							end
						end
						// msb first output from bit 9
						if (state_reg.count >= 5'(DCSER_FRAME_BITS - DCSER_DATA_W)) begin
							state_next.out_bit = state_reg.shift_out[9];
							if (sclk_fall) begin
								state_next.shift_out = {state_reg.shift_out[8:0], 1'b0};
							end
						end else begin
							state_next.out_bit = 1'b0;
						end
					end
					DCSER_DONE: begin
						state_next.done = 1'b1;
						state_next.drive = 1'b0;
					end
					default: begin
						state_next.phase = DCSER_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_reg <= '{phase: DCSER_IDLE, count: 5'h00, shift_in: 16'h0000, shift_out: 10'h000,
				cmd: 3'h0, cfg: DCSER_CFG_RESET, sclk_prev: 1'b1, out_bit: 1'b0, drive: 1'b0,
				done: 1'b0, rd_err: 1'b0, faults: 4'h0};
		end else begin
			state_reg <= state_next;
		end
	end

	// ***********************************
	// outputs
	// ***********************************
	assign serial_out = state_reg.out_bit;
	assign serial_out_en = state_reg.drive;
	// done low starts the next device
	assign frame_done_n = ~state_reg.done;
	// open drain: pull low while the interrupt stands
	assign error_irq_out = 1'b0;
	assign error_irq_en = err_irq;
	assign cfg_mode = state_reg.cfg[DCSER_CFG_MODE_LO +: 3];
	assign cfg_brownout_thr = state_reg.cfg[DCSER_CFG_BOTH_LO +: 3];
	assign cfg_thermal_en = state_reg.cfg[DCSER_CFG_THERM];
endmodule : dcser_slave
`default_nettype wire

// file: tb/dcser_slave_chk.sv
`default_nettype none
module dcser_chk
	import dcser_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic chip_select_a_n,
	input wire logic chip_select_b_n,
	input wire logic fault_short,
	input wire logic fault_open,
	input wire logic fault_overtemp,
	input wire logic fault_brownout,
	input wire logic serial_out_en,
	input wire logic frame_done_n,
	input wire logic error_irq_en,
	input wire logic [2:0] cfg_mode,
	input wire logic [2:0] cfg_brownout_thr,
	input wire logic cfg_thermal_en
);
	// ****
	// recent history
	// ****
	wire logic sel_lo = !chip_select_a_n && !chip_select_b_n;
	wire logic flt = fault_short || fault_open || fault_overtemp || fault_brownout;
	logic [3:0] sel_h;
	logic [3:0] flt_h;
	// pins cross two sync flops, so look back four edges
	always_ff @(posedge mclk) begin
		sel_h <= {sel_h[2:0], sel_lo};
		flt_h <= {flt_h[2:0], flt};
	end
	default clocking @(posedge mclk);
	endclocking
	default disable iff (reset);
	a_float_desel: assert property ((!sel_lo) [*4] |-> !serial_out_en)
		else $error("output driven while idle");
	a_done_clear: assert property ((!sel_lo) [*4] |-> frame_done_n)
		else $error("done held while idle");
	a_done_holds: assert property (sel_lo [*4] ##0 !frame_done_n |=> !frame_done_n)
		else $error("done dropped early");
	a_float_done: assert property (!frame_done_n |-> !serial_out_en)
		else $error("output driven after done");
	a_drive_sel: assert property (sel_lo [*5] ##0 frame_done_n |-> serial_out_en)
		else $error("output not driven");
	a_irq_cause: assert property ($rose(error_irq_en) |-> flt_h != 4'h0)
		else $error("interrupt without fault");
	a_irq_clear: assert property ($fell(error_irq_en) |-> ##[0:3] !frame_done_n)
		else $error("interrupt cleared off frame end");
	a_cfg_steady: assert property (!$stable({cfg_mode, cfg_brownout_thr, cfg_thermal_en}) |-> sel_h != 4'h0)
		else $error("config moved while idle");
	c_done: cover property ($fell(frame_done_n));
	c_irq: cover property ($rose(error_irq_en));
	c_clear: cover property ($fell(error_irq_en));
endmodule : dcser_chk
`default_nettype wire

// file: tb/dcser_host.sv
`default_nettype none
module dcser_host
	import dcser_pkg::*;
(
	input wire logic mclk,
	input wire logic serial_line,
	output logic chip_select_a_n,
	output logic serial_clk,
	output logic serial_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// serial master
	// ****
	initial begin
		chip_select_a_n = 1'b1;
		serial_clk = 1'b1;
		serial_in = 1'b0;
	end
	task automatic xfer(input logic [15:0] w, output logic [15:0] rd);
		if (chip_select_a_n) begin
			@(posedge mclk) chip_select_a_n <= 1'b0;
			repeat (4) @(posedge mclk);
		end
		for (int i = 15; i >= 0; i--) begin
			serial_in <= w[i];
			repeat (3) @(posedge mclk);
			@(negedge mclk) rd[i] = serial_line;
			@(posedge mclk) serial_clk <= 1'b0;
			repeat (4) @(posedge mclk);
			serial_clk <= 1'b1;
		end
	endtask : xfer
	// select only raised after whole frames
	task automatic release_cs();
		@(posedge mclk) chip_select_a_n <= 1'b1;
		// idle data line flips once per release, never a stale value
		serial_in <= ~serial_in;
		repeat (6) @(posedge mclk);
	endtask : release_cs
endmodule : dcser_host
`default_nettype wire

// file: tb/dcser_slave_test.sv
`default_nettype none
module dcser_slave_test
	import dcser_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// bench and model
	// ****
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic chip_select_b_n = 1'b0;
	logic [3:0] flt = 4'h0;
	logic [15:0] rd;
	wire logic chip_select_a_n, serial_clk, serial_in, serial_out, serial_out_en, frame_done_n;
	wire logic error_irq_out, error_irq_en, cfg_thermal_en;
	wire logic [2:0] cfg_mode, cfg_brownout_thr;
	// pull-ups on data and interrupt lines
	wire logic serial_line = serial_out_en ? serial_out : 1'b1;
	wire logic irq_line = error_irq_en ? error_irq_out : 1'b1;
	int fail_count = 0;
	int tests_run = 0;
	int lat = 0;
	int inter = 0;
	int armed = 0;
	int irqm = 0;
	int cfgm = 0;
	always #50 mclk = ~mclk;
	dcser_slave dut (.mclk, .reset, .clk_en(1'b1), .chip_select_a_n, .chip_select_b_n, .serial_clk,
		.serial_in, .serial_out, .serial_out_en, .frame_done_n, .fault_short(flt[3]), .fault_open(flt[2]),
		.fault_overtemp(flt[1]), .fault_brownout(flt[0]), .error_irq_out, .error_irq_en, .cfg_mode,
		.cfg_brownout_thr, .cfg_thermal_en);
	dcser_host host (.mclk, .serial_line, .chip_select_a_n, .serial_clk, .serial_in);
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize();
		if (fail_count == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : summarize
	task automatic faults(input logic [3:0] f);
		@(posedge mclk) flt <= f;
		if ((f & ~lat[3:0]) != 4'h0) begin
			lat = lat | int'(f);
			irqm = 1;
			armed = 0;
		end
		// only short and open leave an intermittent mark
		if ((lat[3:0] & ~f & 4'hC) != 4'h0) inter = 1;
		repeat (12) @(posedge mclk);
		check(16'(irq_line), 16'(irqm == 0));
	endtask : faults
	task automatic frame(input logic [2:0] c, input logic [9:0] d);
		logic [15:0] exp;
		exp = 16'h0000;
		if (c == DCSER_CMD_RDCFG) exp = 16'(cfgm);
		if (c == DCSER_CMD_RDERR) exp = 16'(inter * 512 + lat * 32);
		host.xfer({2'b00, c, 1'b0, d}, rd);
		repeat (5) @(posedge mclk);
		check(16'(frame_done_n), 16'h0000);
		host.release_cs();
		if (c == DCSER_CMD_WRCFG) cfgm = int'(d & DCSER_CFG_MASK);
		if (c == DCSER_CMD_RDERR) begin
			if (armed != 0) begin
				lat = int'(flt);
				inter = 0;
			end
			armed = (armed == 0);
			irqm = 0;
		end
		check(rd, exp);
		check(16'(irq_line), 16'(irqm == 0));
		check({9'h000, cfg_mode, cfg_brownout_thr, cfg_thermal_en}, 16'(cfgm / 8));
	endtask : frame
	initial begin
		void'($urandom(17));
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		repeat (4) @(posedge mclk);
		for (int k = 0; k < 16; k++) frame(3'(k), 10'($urandom));
		// tail of a long frame floats, its write is ignored
		host.xfer(16'h0000, rd);
		host.xfer({5'b00001, 1'b0, 10'(~cfgm)}, rd);
		check(rd, 16'hFFFF);
		host.release_cs();
		// write cut short by the second select
		fork
			host.xfer({5'b00001, 1'b0, 10'(~cfgm)}, rd);
			begin
				repeat (60) @(posedge mclk);
				chip_select_b_n <= 1'b1;
			end
		join
		repeat (5) @(posedge mclk);
		check(16'(frame_done_n), 16'h0001);
		host.release_cs();
		chip_select_b_n <= 1'b0;
		for (int b = 0; b < 4; b++) begin
			faults(4'(1 << b));
			faults(4'h0);
			repeat (2) frame(DCSER_CMD_RDERR, 10'h000);
		end
		faults(4'h8);
		frame(DCSER_CMD_RDERR, 10'h000);
		faults(4'h8);
		faults(4'h9);
		frame(DCSER_CMD_RDERR, 10'h000);
		faults(4'h0);
		repeat (3) frame(DCSER_CMD_RDERR, 10'h000);
		summarize();
	end
	// hang guard, several times the expected run
	initial begin
		#2000000;
		fail_count++;
		summarize();
	end
endmodule : dcser_slave_test
bind dcser_slave dcser_chk chk (.mclk, .reset, .chip_select_a_n, .chip_select_b_n, .fault_short,
	.fault_open, .fault_overtemp, .fault_brownout, .serial_out_en, .frame_done_n, .error_irq_en,
	.cfg_mode, .cfg_brownout_thr, .cfg_thermal_en);
`default_nettype wire
